// ==== src/snfr_defines.vh ====
// constants for the serial nand fast-read path
// assumes inclusion by bare name from design files
`ifndef SNFR_DEFINES_VH
`define SNFR_DEFINES_VH

// ------------------------------------------------------------
// opcodes
// ------------------------------------------------------------
`define SNFR_OP_FAST     8'h0b
`define SNFR_OP_FAST_X   8'h0c
`define SNFR_OP_DUAL     8'h3b
`define SNFR_OP_DUAL_X   8'h3c
`define SNFR_OP_QUAD     8'h6b
`define SNFR_OP_QUAD_X   8'h6c

// ------------------------------------------------------------
// field widths and dummy counts (in link clocks)
// ------------------------------------------------------------
`define SNFR_OP_BITS     6'h08
`define SNFR_COL_BITS    6'h10
`define SNFR_DUM_BUF     6'h08
`define SNFR_DUM_SEQ     6'h20
`define SNFR_DUM_X_BUF   6'h18
`define SNFR_DUM_X_SEQ   6'h28

// ------------------------------------------------------------
// lane widths per output form, and bits per byte
// ------------------------------------------------------------
`define SNFR_LANE_1      3'h1
`define SNFR_LANE_2      3'h2
`define SNFR_LANE_4      3'h4
`define SNFR_BYTE_BITS   4'h8

`endif

// ==== src/snfr_read_path.v ====
// fast-read path of a serial nand device: command decode, dummy phase,
// and streaming of the page data buffer on one, two or four lanes.
// assumes the buffer and array sit outside, answering bufAddr/pageAddr
// with a byte on bufData by the next byte boundary (a few mclk later).
`timescale 1ns/10ps
`include "snfr_defines.vh"

module snfr_read_path #(
    parameter BUF_AW = 12,
    parameter BUF_BYTES = 2176,
    parameter PAGE_AW = 24
) (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // link pins, sampled on mclk
    input wire linkClk,
    input wire chipSelN,
    input wire [3:0] ioIn,
    output reg [3:0] ioOut_q,
    output reg [3:0] ioOe_q,
    // mode and status
    input wire bufMode,
    input wire wpEnable,
    input wire [PAGE_AW-1:0] startPage,
    // data buffer and array port
    output reg [BUF_AW-1:0] bufAddr_q,
    output reg [PAGE_AW-1:0] pageAddr_q,
    input wire [7:0] bufData,
    output reg busy_q
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg [1:0] clkSync_q;
    reg [1:0] csSync_q;
    reg [1:0] dinSync_q;
    reg clkPrev_q;
    wire clkRise = clkSync_q[1] & ~clkPrev_q;
    wire clkFall = ~clkSync_q[1] & clkPrev_q;
    wire csHigh = csSync_q[1];

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clkSync_q <= 2'h0;
            csSync_q <= 2'h3;
            dinSync_q <= 2'h0;
            clkPrev_q <= 1'b0;
        end else begin
            clkSync_q <= {clkSync_q[0], linkClk};
            csSync_q <= {csSync_q[0], chipSelN};
            dinSync_q <= {dinSync_q[0], ioIn[0]};
            clkPrev_q <= clkSync_q[1];
        end
    end

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    localparam ST_IDLE = 3'h0;
    localparam ST_OP = 3'h1;
    localparam ST_COL = 3'h2;
    localparam ST_DUM = 3'h3;
    localparam ST_DATA = 3'h4;
    localparam ST_DONE = 3'h5;
    localparam ST_IGN = 3'h6;

    reg [2:0] state_q;
    reg [7:0] shift_q;
    reg [5:0] bitCnt_q;
    reg [5:0] dumLen_q;
    reg [2:0] lanes_q;
    reg extAddr_q;
    reg seqMode_q;
    reg [7:0] outByte_q;
    reg [3:0] outBits_q;
    reg firstByte_q;
    // set on the last lanes of the final buffer byte in buffer mode
    reg endReached_q;

    wire [7:0] opNext = {shift_q[6:0], dinSync_q[1]};
    wire isQuad = (opNext == `SNFR_OP_QUAD) | (opNext == `SNFR_OP_QUAD_X);
    wire isDual = (opNext == `SNFR_OP_DUAL) | (opNext == `SNFR_OP_DUAL_X);
    wire isExt = (opNext == `SNFR_OP_FAST_X) | (opNext == `SNFR_OP_DUAL_X)
        | (opNext == `SNFR_OP_QUAD_X);
    wire isFast = isExt | isDual | isQuad | (opNext == `SNFR_OP_FAST);
    wire lastBufByte = (bufAddr_q == BUF_BYTES[BUF_AW-1:0] - 1'b1);
    // bits in this byte beyond the ones just sent
    wire [3:0] bitsLeft = outBits_q - {1'b0, lanes_q};

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            bitCnt_q <= 6'h00;
            dumLen_q <= 6'h00;
            lanes_q <= `SNFR_LANE_1;
            extAddr_q <= 1'b0;
            seqMode_q <= 1'b0;
            outByte_q <= 8'h00;
            outBits_q <= 4'h0;
            firstByte_q <= 1'b0;
            endReached_q <= 1'b0;
            ioOut_q <= 4'h0;
            ioOe_q <= 4'h0;
            bufAddr_q <= {BUF_AW{1'b0}};
            pageAddr_q <= {PAGE_AW{1'b0}};
            busy_q <= 1'b0;
        end else if (csHigh) begin
            // select high aborts any phase and frees the pins
            state_q <= ST_OP;
            bitCnt_q <= 6'h00;
            ioOe_q <= 4'h0;
            busy_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_q <= ST_OP;
                    bitCnt_q <= 6'h00;
                end
                ST_OP: if (clkRise) begin
                    // command bits on the single input
                    shift_q <= opNext;
                    bitCnt_q <= bitCnt_q + 6'h01;
                    if (bitCnt_q == `SNFR_OP_BITS - 6'h01) begin
                        bitCnt_q <= 6'h00;
                        extAddr_q <= isExt;
                        seqMode_q <= ~bufMode;
                        // quad forms dropped under write protect
                        if (!isFast || (isQuad && wpEnable)) begin
                            state_q <= ST_IGN;
                        end else begin
                            state_q <= ST_COL;
                            busy_q <= 1'b1;
                        end
                        // lane count per form
                        lanes_q <= isQuad ? `SNFR_LANE_4 :
                            (isDual ? `SNFR_LANE_2 : `SNFR_LANE_1);
                    end
                end
                ST_COL: if (clkRise) begin
                    bitCnt_q <= bitCnt_q + 6'h01;
                    bufAddr_q <= {bufAddr_q[BUF_AW-2:0], dinSync_q[1]};
                    if (bitCnt_q == `SNFR_COL_BITS - 6'h01) begin
                        bitCnt_q <= 6'h00;
                        state_q <= ST_DUM;
                        // dummy length by form and mode
                        if (extAddr_q) begin
                            dumLen_q <= seqMode_q ? `SNFR_DUM_X_SEQ : `SNFR_DUM_X_BUF;
                        end else begin
                            dumLen_q <= seqMode_q ? `SNFR_DUM_SEQ : `SNFR_DUM_BUF;
                        end
                    end
                end
                ST_DUM: begin
                    if (seqMode_q) begin
                        // sequential start ignores the column
                        bufAddr_q <= {BUF_AW{1'b0}};
                        pageAddr_q <= startPage;
                    end
                    if (clkRise) begin
                        bitCnt_q <= bitCnt_q + 6'h01;
                        if (bitCnt_q == dumLen_q - 6'h01) begin
                            state_q <= ST_DATA;
                            outBits_q <= 4'h0;
                            firstByte_q <= 1'b1;
                            endReached_q <= 1'b0;
                        end
                    end
                end
                ST_DATA: if (clkFall) begin
                    // msb first on falling edges
                    if (outBits_q == 4'h0) begin
                        if (!firstByte_q && endReached_q) begin
                            // buffer end reached: release pins
                            state_q <= ST_DONE;
                            ioOe_q <= 4'h0;
                        end else begin
                            firstByte_q <= 1'b0;
                            outByte_q <= bufData << lanes_q;
                            outBits_q <= `SNFR_BYTE_BITS - {1'b0, lanes_q};
                            case (lanes_q)
                                `SNFR_LANE_4: begin
                                    ioOut_q <= bufData[7:4];
                                    ioOe_q <= 4'hf;
                                end
                                `SNFR_LANE_2: begin
                                    ioOut_q <= {2'h0, bufData[7:6]};
                                    ioOe_q <= 4'h3;
                                end
                                default: begin
                                    // single output uses IO1 as data out
                                    ioOut_q <= {2'h0, bufData[7], 1'b0};
                                    ioOe_q <= 4'h2;
                                end
                            endcase
                        end
                    end else begin
                        outByte_q <= outByte_q << lanes_q;
                        outBits_q <= bitsLeft;
                        if (bitsLeft == 4'h0) begin
                            // step on the last lanes so the next byte settles in time
                            endReached_q <= lastBufByte & ~seqMode_q;
                            if (lastBufByte) begin
                                bufAddr_q <= {BUF_AW{1'b0}};
                                if (seqMode_q) begin
                                    // roll into the next page
                                    pageAddr_q <= pageAddr_q + 1'b1;
                                end
                            end else begin
                                bufAddr_q <= bufAddr_q + 1'b1;
                            end
                        end
                        case (lanes_q)
                            `SNFR_LANE_4: ioOut_q <= outByte_q[7:4];
                            `SNFR_LANE_2: ioOut_q <= {2'h0, outByte_q[7:6]};
                            default: ioOut_q <= {2'h0, outByte_q[7], 1'b0};
                        endcase
                    end
                end
                ST_DONE: ioOe_q <= 4'h0;
                ST_IGN: ioOe_q <= 4'h0;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule

// ==== verif/snfr_read_path_asserts.sv ====
// checker for the fast-read path, bound to the design top
// assumes link clock periods of at least 8 mclk
`timescale 1ns/10ps
module snfr_read_path_asserts #(
    parameter BUF_AW = 12,
    parameter BUF_BYTES = 2176,
    parameter PAGE_AW = 24
) (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // link
    input wire linkClk,
    input wire chipSelN,
    input wire [3:0] ioIn,
    input wire [3:0] ioOut_q,
    input wire [3:0] ioOe_q,
    // mode, status, buffer
    input wire bufMode,
    input wire wpEnable,
    input wire [PAGE_AW-1:0] startPage,
    input wire [BUF_AW-1:0] bufAddr_q,
    input wire [PAGE_AW-1:0] pageAddr_q,
    input wire [7:0] bufData,
    input wire busy_q
);
    // raw select low time; no data before 32 link clocks can pass
    reg [15:0] lowCnt_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            lowCnt_q <= 16'h0;
        else if (chipSelN)
            lowCnt_q <= 16'h0;
        else if (lowCnt_q != 16'hffff)
            lowCnt_q <= lowCnt_q + 16'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_early; (ioOe_q != 4'h0 && !chipSelN) |-> lowCnt_q >= 16'h00fa; endproperty
    a_early: assert property (p_early) else $error("output before dummies end");
    property p_cs_stop; chipSelN [*6] |-> (ioOe_q == 4'h0 && !busy_q); endproperty
    a_cs_stop: assert property (p_cs_stop) else $error("output after select high");
    property p_oe_busy; ioOe_q != 4'h0 |-> busy_q; endproperty
    a_oe_busy: assert property (p_oe_busy) else $error("drive without busy");
    property p_oe_legal; ioOe_q inside {4'h0, 4'h2, 4'h3, 4'hf}; endproperty
    a_oe_legal: assert property (p_oe_legal) else $error("bad lane enable");
    property p_wp_quad; $rose(ioOe_q == 4'hf) |-> !wpEnable; endproperty
    a_wp_quad: assert property (p_wp_quad) else $error("quad under protect");
    property p_addr_step;
        ($changed(bufAddr_q) && $past(ioOe_q) != 4'h0 && !chipSelN)
            |-> (bufAddr_q == $past(bufAddr_q) + 1'b1 || bufAddr_q == 0);
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("address skip");
    property p_page_step;
        ($changed(pageAddr_q) && $past(ioOe_q) != 4'h0 && !chipSelN)
            |-> pageAddr_q == $past(pageAddr_q) + 1'b1;
    endproperty
    a_page_step: assert property (p_page_step) else $error("page skip");
    property p_buf_page; (bufMode && ioOe_q != 4'h0 && $past(ioOe_q) != 4'h0) |-> $stable(pageAddr_q); endproperty
    a_buf_page: assert property (p_buf_page) else $error("page moved in buffer mode");
endmodule

bind snfr_read_path snfr_read_path_asserts #(.BUF_AW(BUF_AW), .BUF_BYTES(BUF_BYTES),
    .PAGE_AW(PAGE_AW)) i_chk (.mclk(mclk), .rst_n(rst_n), .linkClk(linkClk),
    .chipSelN(chipSelN), .ioIn(ioIn), .ioOut_q(ioOut_q), .ioOe_q(ioOe_q), .bufMode(bufMode),
    .wpEnable(wpEnable), .startPage(startPage), .bufAddr_q(bufAddr_q),
    .pageAddr_q(pageAddr_q), .bufData(bufData), .busy_q(busy_q));

// ==== verif/snfr_host.sv ====
// host model: frames one command and gathers the reply bytes
// assumes a 50 MHz mclk; one link clock is 8 mclk, idle low
`timescale 1ns/10ps
module snfr_host (
    // clock
    input wire mclk,
    // link
    output reg linkClk,
    output reg chipSelN,
    output reg [3:0] ioIn,
    input wire [3:0] ioOut,
    input wire [3:0] ioOe
);
    reg [7:0] rxByte [0:31];
    reg [3:0] rxOe [0:31];
    initial begin
        linkClk = 1'b0;
        chipSelN = 1'b1;
        ioIn = 4'h5;
    end
    // new bit at the fall, device samples at the rise
    task tick(input b);
        begin
            linkClk <= 1'b0;
            ioIn <= {~ioIn[3:1], b};
            repeat (4) @(posedge mclk);
            linkClk <= 1'b1;
            repeat (4) @(posedge mclk);
        end
    endtask
    task xfer(input [7:0] op, input [15:0] col, input integer nDum, nByte, lanes);
        integer i, k;
        reg [7:0] sh;
        begin
            sh = 8'h0;
            @(posedge mclk);
            chipSelN <= 1'b0;
            for (i = 7; i >= 0; i = i - 1)
                tick(op[i]);
            for (i = 15; i >= 0; i = i - 1)
                tick(col[i]);
            for (i = 0; i < nDum; i = i + 1)
                tick(~ioIn[0]);
            for (i = 0; i < nByte; i = i + 1) begin
                for (k = 0; k < 8 / lanes; k = k + 1) begin
                    tick(~ioIn[0]);
                    // sample late in the high phase, well after the fall
                    rxOe[i] = ioOe;
                    sh = lanes == 1 ? {sh[6:0], ioOut[1]} : lanes == 2 ?
                        {sh[5:0], ioOut[1:0]} : {sh[3:0], ioOut};
                end
                rxByte[i] = sh;
            end
            linkClk <= 1'b0;
            @(posedge mclk);
            chipSelN <= 1'b1;
            ioIn <= ~ioIn;
        end
    endtask
endmodule

// ==== verif/tb_snfr_read_path.sv ====
// bench for the fast-read path with a small 16-byte buffer
// assumes the host model in snfr_host and a pattern buffer model here
`timescale 1ns/10ps
module tb_snfr_read_path;
    localparam NB = 16;
    reg mclk = 1'b0;
    reg rst_n = 1'b0;
    reg bufMode = 1'b1;
    reg wpEnable = 1'b0;
    reg [23:0] startPage = 24'h000003;
    wire linkClk, chipSelN, busy_q;
    wire [3:0] ioIn, ioOut_q, ioOe_q;
    wire [11:0] bufAddr_q;
    wire [23:0] pageAddr_q;
    // buffer pattern; array pages carry their number in the top nibble
    wire [7:0] bufData = bufMode ? {~bufAddr_q[3:0], bufAddr_q[3:0]} :
        {pageAddr_q[3:0], bufAddr_q[3:0]};
    integer mismatches = 0;
    integer checks = 0;
    always #10 mclk = ~mclk;
    snfr_read_path #(.BUF_BYTES(NB)) i_dut (.mclk(mclk), .rst_n(rst_n), .linkClk(linkClk),
        .chipSelN(chipSelN), .ioIn(ioIn), .ioOut_q(ioOut_q), .ioOe_q(ioOe_q),
        .bufMode(bufMode), .wpEnable(wpEnable), .startPage(startPage), .bufAddr_q(bufAddr_q),
        .pageAddr_q(pageAddr_q), .bufData(bufData), .busy_q(busy_q));
    snfr_host i_host (.mclk(mclk), .linkClk(linkClk), .chipSelN(chipSelN), .ioIn(ioIn),
        .ioOut(ioOut_q), .ioOe(ioOe_q));
    task cmp8(input [8*6:1] what, input [7:0] e, input [7:0] s);
        begin
            checks = checks + 1;
            if (s !== e) begin
                mismatches = mismatches + 1;
                $display("BAD %0s expected %h seen %h", what, e, s);
            end
        end
    endtask
    task cmp4(input [8*6:1] what, input [3:0] e, input [3:0] s);
        cmp8(what, {4'h0, e}, {4'h0, s});
    endtask
    // one frame, then judge each byte and the quiet after select high
    task run(input [7:0] op, input [15:0] col, input m, input integer nDum, nb, lanes, first,
        input [3:0] oe);
        integer i, a, p;
        begin
            @(posedge mclk);
            bufMode <= m;
            i_host.xfer(op, col, nDum, nb, lanes);
            for (i = 0; i < nb; i = i + 1) begin
                a = first + i;
                p = startPage + a / NB;
                if (m && a >= NB)
                    cmp4("hiz", 4'h0, i_host.rxOe[i]);
                else begin
                    cmp4("oe", oe, i_host.rxOe[i]);
                    if (oe != 4'h0)
                        cmp8("byte", m ? {~a[3:0], a[3:0]} : {p[3:0], a[3:0]},
                            i_host.rxByte[i]);
                end
            end
            repeat (6) @(posedge mclk);
            cmp4("idle", 4'h0, ioOe_q);
            cmp4("busy", 4'h0, {3'h0, busy_q});
        end
    endtask
    task t_single_buf;
        begin
            run(8'h0b, 16'h000d, 1'b1, 8, 4, 1, 13, 4'h2);
            $display("single buffer read done");
        end
    endtask
    task t_seq;
        begin
            run(8'h0c, 16'h0005, 1'b0, 40, 18, 1, 0, 4'h2);
            run(8'h0b, 16'h0007, 1'b0, 32, 2, 1, 0, 4'h2);
            $display("sequential read done");
        end
    endtask
    task t_multi;
        begin
            run(8'h3b, 16'h0002, 1'b1, 8, 2, 2, 2, 4'h3);
            run(8'h3c, 16'h000e, 1'b1, 24, 3, 2, 14, 4'h3);
            run(8'h6b, 16'h0002, 1'b1, 8, 2, 4, 2, 4'hf);
            run(8'h6c, 16'h0000, 1'b0, 40, 17, 4, 0, 4'hf);
            $display("dual and quad reads done");
        end
    endtask
    task t_wp;
        begin
            wpEnable <= 1'b1;
            run(8'h6b, 16'h0001, 1'b1, 8, 2, 4, 1, 4'h0);
            run(8'h6c, 16'h0001, 1'b1, 24, 2, 4, 1, 4'h0);
            run(8'h3b, 16'h0001, 1'b1, 8, 1, 2, 1, 4'h3);
            wpEnable <= 1'b0;
            $display("write protect done");
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", checks, mismatches);
            if (mismatches == 0 && checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        // buffer model holds the page at once, so no busy wait is needed
        repeat (4) @(posedge mclk);
        t_single_buf;
        t_seq;
        t_multi;
        t_wp;
        close_out;
    end
    // all frames together take well under 12000 mclk
    initial begin
        repeat (30000) @(posedge mclk);
        mismatches = mismatches + 1;
        close_out;
    end
endmodule
